// ===== shared/fsdl_params.svh
/*
 * Constants of the flash security debug lock: security byte locations,
 * the unsecure key, reset values and the release window length.
 * Assumes it is included by its bare name from design files only.
 */
// Overview of operation
// - Security state comes from nonvolatile configuration bytes, surviving reset and power loss.
// - Exactly two configuration bytes decide security; no other byte matters.
// - At boot the system integration module picks unsecured or secure mode.
// - Secure mode disables every debug feature of the emulation debug port.
// - Instruction fetch and program execution stay the same in both modes.
// - Debug flash read commands are accepted only while unsecured.
// - The debug port rides on the JTAG pins TRST, TCK, TMS, TDI, TDO.
// - Reset release gives a 32 clock window to apply flash security.
`ifndef FSDL_PARAMS_SVH
`define FSDL_PARAMS_SVH

// ----------------------------------------------------------------------
// security bytes in the flash configuration field
// ----------------------------------------------------------------------
`define FSDL_SEC_ADDR_LO   16'h0000
`define FSDL_SEC_ADDR_HI   16'h0001
`define FSDL_UNSEC_KEY_LO  8'h00
`define FSDL_UNSEC_KEY_HI  8'h00

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define FSDL_SECURE_RST    1'b1
`define FSDL_WIN_CLOCKS    32
`define FSDL_WIN_LAST      6'h1F
`define FSDL_CNT_W         6

`endif

// ===== shared/fsdl_pkg.sv
/*
 * Types of the flash security debug lock.
 * Assumes nothing of its surroundings.
 */
package fsdl_pkg;

  // gray codes along the boot path
  typedef enum logic [2:0] {
    FSDL_ST_RD_LO = 3'h1,
    FSDL_ST_RD_HI = 3'h3,
    FSDL_ST_HOLD  = 3'h2,
    FSDL_ST_DONE  = 3'h6
  } fsdl_state_t;

endpackage

// ===== verilog/fsdl_security_lock.sv
/*
 * Flash security debug lock: reads the two security bytes during the
 * peripheral release window after reset, fixes the mode, and gates the
 * on-chip emulation debug port behind the JTAG pins.
 * Assumes a flash configuration read port that answers with an ack and
 * a reset controller that holds rst_i until clocks are stable.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fsdl_params.svh"

module fsdl_security_lock (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // flash configuration field read port
  output logic             sec_rd_req_o,
  output logic [15:0]      sec_rd_addr_o,
  input  wire logic [7:0]  sec_rd_data_i,
  input  wire logic        sec_rd_ack_i,
  // mode and release status
  output logic             window_active_o,
  output logic             boot_done_o,
  output logic             secure_o,
  // JTAG pins from the debug host
  input  wire logic        trst_n_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  // JTAG toward the on_chip_emulation_debug_port
  output logic             dbg_trst_n_o,
  output logic             dbg_tck_o,
  output logic             dbg_tms_o,
  output logic             dbg_tdi_o,
  input  wire logic        dbg_tdo_i,
  input  wire logic        dbg_tdo_oe_i,
  // debug flash reads toward the flash_memory_array
  input  wire logic        dbg_flash_rd_req_i,
  output logic             flash_dbg_rd_req_o,
  // core instruction fetch toward the flash_memory_array
  input  wire logic        cpu_fetch_req_i,
  output logic             flash_fetch_req_o
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // fail closed: any value other than the key keeps the part secure
  function automatic logic fsdl_is_unsecured(input logic [7:0] lo, input logic [7:0] hi);
    fsdl_is_unsecured = (lo == `FSDL_UNSEC_KEY_LO) && (hi == `FSDL_UNSEC_KEY_HI);
  endfunction

  fsdl_pkg::fsdl_state_t        state;
  fsdl_pkg::fsdl_state_t        next_state;
  logic [`FSDL_CNT_W-1:0]       win_cnt;
  logic [7:0]                   byte_lo;
  logic [7:0]                   byte_hi;
  logic                         bytes_ok;
  logic                         mode_fixed;

  wire logic win_end   = (win_cnt == `FSDL_WIN_LAST);
  wire logic take_lo   = (state == fsdl_pkg::FSDL_ST_RD_LO) && sec_rd_ack_i;
  wire logic take_hi   = (state == fsdl_pkg::FSDL_ST_RD_HI) && sec_rd_ack_i;
  wire logic decision  = ~(bytes_ok && fsdl_is_unsecured(byte_lo, byte_hi));

  // ----------------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------------
  // next state: window end overrides any read still in flight
  always_comb begin
    next_state = state;
    case (state)
      fsdl_pkg::FSDL_ST_RD_LO: if (take_lo) next_state = fsdl_pkg::FSDL_ST_RD_HI;
      fsdl_pkg::FSDL_ST_RD_HI: if (take_hi) next_state = fsdl_pkg::FSDL_ST_HOLD;
      fsdl_pkg::FSDL_ST_HOLD:  next_state = fsdl_pkg::FSDL_ST_HOLD;
      fsdl_pkg::FSDL_ST_DONE:  next_state = fsdl_pkg::FSDL_ST_DONE;
      default:                 next_state = fsdl_pkg::FSDL_ST_DONE;
    endcase
    if (state != fsdl_pkg::FSDL_ST_DONE && win_end) begin
      next_state = fsdl_pkg::FSDL_ST_DONE;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state   <= fsdl_pkg::FSDL_ST_RD_LO;
      win_cnt <= '0;
    end else begin
      state   <= next_state;
      win_cnt <= mode_fixed ? win_cnt : win_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      byte_lo  <= 8'hFF;
      byte_hi  <= 8'hFF;
      bytes_ok <= 1'b0;
    end else begin
      if (take_lo) byte_lo <= sec_rd_data_i;
      if (take_hi) byte_hi <= sec_rd_data_i;
      if (take_hi) bytes_ok <= 1'b1;
    end
  end

  // mode fixed once, secure until proven otherwise
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      secure_o   <= `FSDL_SECURE_RST;
      mode_fixed <= 1'b0;
    end else if (!mode_fixed && win_end) begin
      secure_o   <= decision;
      mode_fixed <= 1'b1;
    end
  end

  // read port addresses the two bytes in order
  assign sec_rd_req_o    = (state == fsdl_pkg::FSDL_ST_RD_LO) ||
                           (state == fsdl_pkg::FSDL_ST_RD_HI);
  assign sec_rd_addr_o   = (state == fsdl_pkg::FSDL_ST_RD_HI) ? `FSDL_SEC_ADDR_HI
                                                              : `FSDL_SEC_ADDR_LO;
  assign window_active_o = ~mode_fixed;
  assign boot_done_o     = mode_fixed;

  // ----------------------------------------------------------------------
  // debug port gating
  // ----------------------------------------------------------------------
  // debug blocked when secure; TAP of the port held in reset
  assign dbg_trst_n_o = secure_o ? 1'b0 : trst_n_i;
  assign dbg_tck_o    = secure_o ? 1'b0 : tck_i;
  assign dbg_tms_o    = secure_o ? 1'b1 : tms_i;
  assign dbg_tdi_o    = secure_o ? 1'b0 : tdi_i;
  assign tdo_o        = secure_o ? 1'b0 : dbg_tdo_i;
  assign tdo_oe_o     = ~secure_o & dbg_tdo_oe_i;

  // debug flash reads only when unsecured
  assign flash_dbg_rd_req_o = dbg_flash_rd_req_i & ~secure_o;

  assign flash_fetch_req_o  = cpu_fetch_req_i;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_lo_taken;
    take_lo && !win_end;
  endsequence

  sequence s_hi_asked;
    sec_rd_req_o && (sec_rd_addr_o == `FSDL_SEC_ADDR_HI);
  endsequence

  sequence s_lo_asked;
    sec_rd_req_o && (sec_rd_addr_o == `FSDL_SEC_ADDR_LO);
  endsequence

  // first read of a window always goes to the low byte
  AST_FIRST_READ_LO: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    win_cnt == 6'h00 && !mode_fixed |-> s_lo_asked)
    else $error("first security read not at low byte");

  // unsecuring is only legal from a complete key pair
  AST_UNSECURE_PAIR: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(secure_o) |-> $past(bytes_ok) && $past(byte_lo) == `FSDL_UNSEC_KEY_LO &&
      $past(byte_hi) == `FSDL_UNSEC_KEY_HI)
    else $error("unsecured without both key bytes");

  // no byte fetched once the mode is frozen
  AST_NO_LATE_READ: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) mode_fixed |-> !sec_rd_req_o)
    else $error("security byte read after mode fixed");

  // parked TAP pins and blocked flash reads while secure
  AST_TAP_PARKED: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    secure_o |-> dbg_tms_o && !dbg_tdi_o && !flash_dbg_rd_req_o && !tdo_o)
    else $error("debug pins not parked while secure");

  AST_SECURE_UNTIL_FIXED: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) !mode_fixed |-> secure_o)
    else $error("part not secure before mode fixed");

  AST_TWO_BYTE_DECIDE: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !mode_fixed && win_end |=> secure_o == $past(decision))
    else $error("mode not taken from the two bytes");

  AST_READ_ORDER: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) s_lo_taken |=> s_hi_asked)
    else $error("second byte not read after first");

  AST_MODE_BY_WINDOW: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(mode_fixed) |-> $past(win_cnt) == `FSDL_WIN_LAST)
    else $error("mode chosen outside window end");

  AST_DEBUG_BLOCKED: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    secure_o |-> !dbg_trst_n_o && !dbg_tck_o && !tdo_oe_o)
    else $error("debug port reachable while secure");

  AST_FETCH_FREE: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) flash_fetch_req_o == cpu_fetch_req_i)
    else $error("fetch altered by security");

  AST_DBG_READ: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    dbg_flash_rd_req_i |-> flash_dbg_rd_req_o == !secure_o)
    else $error("debug read gating wrong");

  AST_JTAG_PASS: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !secure_o |-> dbg_tck_o == tck_i && dbg_tms_o == tms_i && tdo_o == dbg_tdo_i)
    else $error("jtag not passed when unsecured");

  AST_WINDOW_LEN: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    window_active_o && win_cnt == 6'h00 |->
      window_active_o [*8] ##24 !boot_done_o ##1 boot_done_o)
    else $error("release window not 32 clocks");

  AST_MODE_HELD: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    mode_fixed |=> mode_fixed && $stable(secure_o))
    else $error("mode changed after capture");

endmodule

`default_nettype wire

// ===== test/fsdl_flash_model.sv
/*
 * Flash configuration field model answering security byte reads.
 * Assumes the reader holds request and address until the ack pulse.
 */
`timescale 1ns/100ps
`default_nettype none

module fsdl_flash_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  lo_i,
  input  wire logic [7:0]  hi_i,
  input  wire logic [4:0]  dly_i,
  output logic      [7:0]  data_o,
  output logic             ack_o
);
  logic [4:0] cnt;

  // two stored bytes, picked by address bit 0
  // idle data toggles so a stale byte never passes for a fresh one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt    <= 5'h00;
      ack_o  <= 1'b0;
      data_o <= 8'hA5;
    end else begin
      ack_o  <= 1'b0;
      data_o <= ~data_o;
      if (req_i && !ack_o) begin
        cnt <= cnt + 5'h01;
        if (cnt == dly_i) begin
          cnt    <= 5'h00;
          ack_o  <= 1'b1;
          data_o <= addr_i[0] ? hi_i : lo_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/test_flash_security_debug_lock.sv
/*
 * Bench of the flash security debug lock: boots with several byte
 * pairs, checks window length, mode and debug gating.
 * Assumes the flash model answers the security byte reads.
 */
`timescale 1ns/100ps
`default_nettype none

module test_flash_security_debug_lock;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic trst_n_i, tck_i, tms_i, tdi_i, dbg_tdo_i, dbg_tdo_oe_i;
  logic dbg_flash_rd_req_i, cpu_fetch_req_i, sec_rd_ack_i, sec_rd_req_o;
  logic window_active_o, boot_done_o, secure_o, tdo_o, tdo_oe_o;
  logic dbg_trst_n_o, dbg_tck_o, dbg_tms_o, dbg_tdi_o;
  logic flash_dbg_rd_req_o, flash_fetch_req_o;
  logic [15:0] sec_rd_addr_o;
  logic [7:0] sec_rd_data_i, lo, hi;
  logic [4:0] dly;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  fsdl_security_lock i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sec_rd_req_o(sec_rd_req_o), .sec_rd_addr_o(sec_rd_addr_o),
    .sec_rd_data_i(sec_rd_data_i), .sec_rd_ack_i(sec_rd_ack_i),
    .window_active_o(window_active_o), .boot_done_o(boot_done_o),
    .secure_o(secure_o), .trst_n_i(trst_n_i), .tck_i(tck_i), .tms_i(tms_i),
    .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .dbg_trst_n_o(dbg_trst_n_o),
    .dbg_tck_o(dbg_tck_o), .dbg_tms_o(dbg_tms_o), .dbg_tdi_o(dbg_tdi_o),
    .dbg_tdo_i(dbg_tdo_i), .dbg_tdo_oe_i(dbg_tdo_oe_i),
    .dbg_flash_rd_req_i(dbg_flash_rd_req_i), .flash_dbg_rd_req_o(flash_dbg_rd_req_o),
    .cpu_fetch_req_i(cpu_fetch_req_i), .flash_fetch_req_o(flash_fetch_req_o));

  fsdl_flash_model i_flash (.clk_i(clk_sys_i), .rst_i(rst_i), .req_i(sec_rd_req_o),
    .addr_i(sec_rd_addr_o), .lo_i(lo), .hi_i(hi), .dly_i(dly),
    .data_o(sec_rd_data_i), .ack_o(sec_rd_ack_i));

  // clock and hang guard; a run takes a few hundred cycles
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // reset for 12 cycles, then count edges until the mode is fixed
  task automatic boot(input logic [7:0] l, input logic [7:0] h, input logic [4:0] d,
                      input logic s);
    int n;
    @(posedge clk_sys_i);
    lo <= l;
    hi <= h;
    dly <= d;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n == 5) chk("win_tck", dbg_tck_o, 8'h00);
      if (n == 5) chk("win_rd", flash_dbg_rd_req_o, 8'h00);
    end while (boot_done_o !== 1'b1 && n < 40);
    chk("win_len", 8'(n), 8'h20);
    chk("win_act", window_active_o, 8'h00);
    chk("secure", secure_o, s);
  endtask

  // both levels on every debug pin; passthrough only when unsecured
  task automatic gate(input logic s);
    logic v;
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      @(posedge clk_sys_i);
      trst_n_i <= v;
      tck_i <= v;
      tms_i <= !v;
      tdi_i <= v;
      dbg_tdo_i <= v;
      dbg_tdo_oe_i <= v;
      dbg_flash_rd_req_i <= v;
      cpu_fetch_req_i <= v;
      @(posedge clk_sys_i);
      #1;
      chk("trst", dbg_trst_n_o, v & !s);
      chk("tck", dbg_tck_o, v & !s);
      chk("tms", dbg_tms_o, !v | s);
      chk("tdi", dbg_tdi_o, v & !s);
      chk("tdo_oe", tdo_oe_o, v & !s);
      if (!s) chk("tdo", tdo_o, v);
      chk("dbg_rd", flash_dbg_rd_req_o, v & !s);
      chk("fetch", flash_fetch_req_o, v);
      chk("held", secure_o, s);
    end
  endtask

  task automatic sc_open_fast(); boot(8'h00, 8'h00, 5'h00, 1'b0); gate(1'b0); endtask
  task automatic sc_open_slow(); boot(8'h00, 8'h00, 5'h05, 1'b0); gate(1'b0); endtask
  task automatic sc_hi_set(); boot(8'h00, 8'h01, 5'h00, 1'b1); gate(1'b1); endtask
  task automatic sc_lo_set(); boot(8'h5A, 8'h00, 5'h02, 1'b1); gate(1'b1); endtask
  // pair not complete inside the window must fail closed
  task automatic sc_late(); boot(8'h00, 8'h00, 5'h14, 1'b1); gate(1'b1); endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {trst_n_i, tck_i, tms_i, tdi_i} <= 4'hF;
    {dbg_tdo_i, dbg_tdo_oe_i, dbg_flash_rd_req_i, cpu_fetch_req_i} <= 4'hF;
    {lo, hi, dly} <= 21'h0;
    sc_open_fast();
    sc_hi_set();
    sc_open_slow();
    sc_lo_set();
    sc_late();
    final_report();
  end
endmodule
`default_nettype wire
